// ---- pkg/prk_pkg.sv ----
// prk_pkg: constants and carrier types for the pulse ratio keypad editor
// assumes a 125 MHz system clock and debounced key levels from the panel
package prk_pkg;
   localparam int unsigned CLK_HZ          = 125000000;
   localparam int unsigned LONG_PRESS_MS   = 1000;
   localparam int unsigned LONG_PRESS_CYC  = (CLK_HZ / 1000) * LONG_PRESS_MS;
   localparam int unsigned FLASH_MS        = 250;
   localparam int unsigned FLASH_CYC       = (CLK_HZ / 1000) * FLASH_MS;
   localparam int unsigned FLASH_COUNT     = 3;
   localparam int unsigned DIGITS          = 5;
   localparam logic [15:0] PULSE_DIV_ID    = 16'h0c04;
   localparam logic [15:0] UPPER_RESET     = 16'h0001;
   localparam logic [15:0] LOWER_RESET     = 16'h0001;
   localparam logic [15:0] LOWER_SMALL_MAX = 16'h0040;
   localparam logic [15:0] LOWER_LARGE     = 16'h8000;
   localparam logic [15:0] UPPER_ONE       = 16'h0001;
   localparam logic [15:0] UPPER_TWO       = 16'h0002;
   localparam logic [15:0] LOWER_TWO_MIN   = 16'h0003;
   localparam logic [15:0] UPPER_LARGE_MAX = 16'h7fff;

   typedef struct packed {
      logic up;
      logic down;
      logic cursor;
      logic mode;
      logic commit;
   } prk_keys_t;

   typedef enum logic [5:0] {
      PRK_SELECT = 6'h01,
      PRK_PROMPT = 6'h02,
      PRK_EDIT   = 6'h04,
      PRK_FLASH  = 6'h08,
      PRK_SHOW   = 6'h10,
      PRK_REJECT = 6'h20
   } prk_state_t;

   typedef struct packed {
      logic [15:0] value;
      logic [2:0]  cursor;
      logic        digit_blink;
      logic        all_blank;
      logic        show_prompt;
      logic        lower_sel;
   } prk_disp_t;
endpackage : prk_pkg

// ---- rtl/prk_editor.sv ----
// prk_editor: front-panel editor for the encoder pulse division ratio
// assumes keys arrive as asynchronous levels; display driver is outside
//
// Behaviour
// - selection: keys change parameter id
// - long mode toggles upper and lower prompt
// - long commit opens term, rightmost digit blinks
// - up/down adjust value, cursor moves digit
// - valid commit stores, flashes three times
// - invalid commit rejected, old value shown
// - accept only three ratio ranges
// - new upper checked against stored lower
// - upper one allows lower 1..64 or 32768
`timescale 1ns/1ps
module prk_editor
   import prk_pkg::*;
#(
   parameter int unsigned HOLD_CYC  = LONG_PRESS_CYC,
   parameter int unsigned BLINK_CYC = FLASH_CYC
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire prk_pkg::prk_keys_t keys_in,
   output prk_pkg::prk_disp_t     disp,
   output logic [15:0]            param_id,
   output logic [15:0]            upper_ratio_term,
   output logic [15:0]            lower_ratio_term,
   output prk_pkg::prk_state_t    state_out
);
   import prk_pkg::*;

   prk_keys_t  key_meta;
   prk_keys_t  key_sync;
   prk_keys_t  key_prev;
   logic [26:0] hold_cnt;
   logic        hold_fired;
   logic        long_mode;
   logic        long_commit;
   logic        tap_up;
   logic        tap_down;
   logic        tap_cursor;
   prk_state_t  state;
   logic        lower_sel;
   logic [15:0] edit_value;
   logic [2:0]  cursor;
   logic [24:0] flash_cnt;
   logic [2:0]  flash_num;
   logic        flash_on;
   logic [15:0] step;
   logic        ratio_ok;
   logic [15:0] chk_upper;
   logic [15:0] chk_lower;

   // two-stage synchroniser on key levels
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         key_meta <= '0;
         key_sync <= '0;
         key_prev <= '0;
      end else begin
         key_meta <= keys_in;
         key_sync <= key_meta;
         key_prev <= key_sync;
      end
   end

   assign tap_up     = key_sync.up && !key_prev.up;
   assign tap_down   = key_sync.down && !key_prev.down;
   assign tap_cursor = key_sync.cursor && !key_prev.cursor;

   // hold timer for mode and commit, fires once per press
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hold_cnt   <= '0;
         hold_fired <= 1'b0;
      end else if (!(key_sync.mode || key_sync.commit)) begin
         hold_cnt   <= '0;
         hold_fired <= 1'b0;
      end else if (hold_cnt == 27'(HOLD_CYC - 1)) begin
         hold_fired <= 1'b1;
      end else begin
         hold_cnt <= hold_cnt + 27'h1;
      end
   end

   assign long_mode   = key_sync.mode && !key_sync.commit && !hold_fired
                        && hold_cnt == 27'(HOLD_CYC - 1);
   assign long_commit = key_sync.commit && !key_sync.mode && !hold_fired
                        && hold_cnt == 27'(HOLD_CYC - 1);

   // decimal-ish step for the digit under the cursor
   always_comb begin
      case (cursor)
         3'h0: step = 16'h0001;
         3'h1: step = 16'h000a;
         3'h2: step = 16'h0064;
         3'h3: step = 16'h03e8;
         default: step = 16'h2710;
      endcase
   end

   // range check, pairing a new term with the stored other term
   always_comb begin
      chk_upper = lower_sel ? upper_ratio_term : edit_value;
      chk_lower = lower_sel ? edit_value : lower_ratio_term;
      ratio_ok  = 1'b0;
      if (chk_upper == UPPER_ONE && chk_lower >= 16'h0001
          && chk_lower <= LOWER_SMALL_MAX) begin
         ratio_ok = 1'b1;
      end else if (chk_upper == UPPER_TWO && chk_lower >= LOWER_TWO_MIN
                   && chk_lower <= LOWER_SMALL_MAX) begin
         ratio_ok = 1'b1;
      end else if (chk_lower == LOWER_LARGE && chk_upper >= 16'h0001
                   && chk_upper <= UPPER_LARGE_MAX) begin
         ratio_ok = 1'b1;
      end
   end

   // editor state machine
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= PRK_SELECT;
         lower_sel <= 1'b0;
      end else begin
         case (state)
            PRK_SELECT: begin
               if (long_commit && param_id == PULSE_DIV_ID) begin
                  state     <= PRK_PROMPT;
                  lower_sel <= 1'b0;
               end
            end
            PRK_PROMPT: begin
               if (long_mode) begin
                  lower_sel <= !lower_sel;
               end else if (long_commit) begin
                  state <= PRK_EDIT;
               end else if (tap_cursor && key_sync.mode) begin
                  state <= PRK_SELECT;
               end
            end
            PRK_EDIT: begin
               if (long_commit) begin
                  state <= ratio_ok ? PRK_FLASH : PRK_REJECT;
               end
            end
            PRK_FLASH: begin
               if (flash_num == 3'(FLASH_COUNT * 2 - 1) && flash_cnt == '0) begin
                  state <= PRK_SHOW;
               end
            end
            PRK_SHOW, PRK_REJECT: begin
               if (key_sync.mode && !key_prev.mode) begin
                  state <= PRK_SELECT;
               end
            end
            default: state <= PRK_SELECT;
         endcase
      end
   end

   // parameter id selection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         param_id <= '0;
      end else if (state == PRK_SELECT) begin
         if (tap_up) begin
            param_id <= param_id + 16'h0001;
         end else if (tap_down) begin
            param_id <= param_id - 16'h0001;
         end else if (tap_cursor) begin
            param_id <= {param_id[11:0], param_id[15:12]};
         end
      end
   end

   // working value and cursor
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         edit_value <= '0;
         cursor     <= '0;
      end else if (state == PRK_PROMPT && long_commit) begin
         edit_value <= lower_sel ? lower_ratio_term : upper_ratio_term;
         cursor     <= '0;
      end else if (state == PRK_EDIT) begin
         if (tap_up) begin
            edit_value <= edit_value + step;
         end else if (tap_down) begin
            edit_value <= edit_value - step;
         end else if (tap_cursor) begin
            cursor <= (cursor == 3'(DIGITS - 1)) ? '0 : cursor + 3'h1;
         end
      end
   end

   // stored terms change only on a valid commit
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         upper_ratio_term <= UPPER_RESET;
         lower_ratio_term <= LOWER_RESET;
      end else if (state == PRK_EDIT && long_commit && ratio_ok) begin
         if (lower_sel) begin
            lower_ratio_term <= edit_value;
         end else begin
            upper_ratio_term <= edit_value;
         end
      end
   end

   // flash sequencer: three off/on cycles
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flash_cnt <= '0;
         flash_num <= '0;
         flash_on  <= 1'b0;
      end else if (state != PRK_FLASH) begin
         flash_cnt <= 25'(BLINK_CYC - 1);
         flash_num <= '0;
         flash_on  <= 1'b0;
      end else if (flash_cnt != '0) begin
         flash_cnt <= flash_cnt - 25'h1;
      end else if (flash_num != 3'(FLASH_COUNT * 2)) begin
         flash_cnt <= 25'(BLINK_CYC - 1);
         flash_num <= flash_num + 3'h1;
         flash_on  <= !flash_on;
      end
   end

   // display carrier
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         disp <= '0;
      end else begin
         disp.lower_sel   <= lower_sel;
         disp.show_prompt <= (state == PRK_PROMPT);
         disp.cursor      <= cursor;
         disp.digit_blink <= (state == PRK_EDIT) || (state == PRK_SELECT);
         disp.all_blank   <= (state == PRK_FLASH) && !flash_on;
         if (state == PRK_SELECT) begin
            disp.value <= param_id;
         end else if (state == PRK_EDIT || state == PRK_FLASH) begin
            disp.value <= edit_value;
         end else begin
            disp.value <= lower_sel ? lower_ratio_term : upper_ratio_term;
         end
      end
   end

   assign state_out = state;

   a_reject_keeps_terms: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PRK_EDIT && long_commit && !ratio_ok) |=>
      ($stable(upper_ratio_term) && $stable(lower_ratio_term) && state == PRK_REJECT))
      else $error("rejected value changed a stored term");
   a_valid_goes_flash: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PRK_EDIT && long_commit && ratio_ok) |=> state == PRK_FLASH)
      else $error("valid commit did not flash");
   a_mode_toggles_term: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PRK_PROMPT && long_mode) |=> lower_sel != $past(lower_sel))
      else $error("long mode did not toggle term");
   a_lower_range_ok: assert property (@(posedge clk) disable iff (!rst_n)
      (upper_ratio_term == UPPER_ONE) |->
      ((lower_ratio_term >= 16'h0001 && lower_ratio_term <= LOWER_SMALL_MAX)
       || lower_ratio_term == LOWER_LARGE))
      else $error("stored lower term out of range");
   a_stored_ratio_ok: assert property (@(posedge clk) disable iff (!rst_n)
      (upper_ratio_term == UPPER_TWO) |-> lower_ratio_term >= LOWER_TWO_MIN)
      else $error("stored ratio out of range");
   a_long_once: assert property (@(posedge clk) disable iff (!rst_n)
      long_commit |=> !long_commit [*8])
      else $error("long press acted twice");
   a_edit_opens_value: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PRK_PROMPT && long_commit) |=> (state == PRK_EDIT && cursor == '0))
      else $error("commit did not open term");
   a_select_id_up: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PRK_SELECT && tap_up) |=> param_id == $past(param_id) + 16'h0001)
      else $error("id did not advance");
   a_edit_step_up: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PRK_EDIT && tap_up && !long_commit) |=>
      edit_value == $past(edit_value) + $past(step))
      else $error("value did not step");
endmodule : prk_editor

// ---- tb/prk_operator.sv ----
// prk_operator: operator at the front panel, pressing and releasing keys
// assumes the bench calls its tasks; keys change only at the falling edge
`timescale 1ns/1ps
module prk_operator
   import prk_pkg::*;
(
   input  wire logic       clk,
   output prk_pkg::prk_keys_t keys
);
   import prk_pkg::*;

   // key masks: up 10, down 08, cursor 04, mode 02, commit 01
   initial keys = prk_keys_t'(5'h00);

   // press a set of keys for n cycles, then release and let the panel settle
   task automatic hold(input logic [4:0] mask, input int n);
      @(negedge clk);
      keys = prk_keys_t'(mask);
      repeat (n) @(negedge clk);
      keys = prk_keys_t'(5'h00);
      repeat (6) @(negedge clk);
   endtask : hold

   task automatic tap(input logic [4:0] mask);
      hold(mask, 4);
   endtask : tap
endmodule : prk_operator

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the pulse ratio keypad editor
// assumes the editor's hold and blink lengths are shortened for the run
`timescale 1ns/1ps
module tb_top;
   import prk_pkg::*;

   logic               clk;
   logic               rst_n;
   prk_keys_t          keys;
   prk_disp_t          disp;
   logic [15:0]        param_id;
   logic [15:0]        upper_ratio_term;
   logic [15:0]        lower_ratio_term;
   prk_state_t         state_out;
   int                 fails;
   int                 n_checks;

   localparam int      T_HOLD  = 32;
   localparam int      T_BLINK = 40;

   prk_editor #(
      .HOLD_CYC  (T_HOLD),
      .BLINK_CYC (T_BLINK)
   ) dut_u (
      .clk              (clk),
      .rst_n            (rst_n),
      .keys_in          (keys),
      .disp             (disp),
      .param_id         (param_id),
      .upper_ratio_term (upper_ratio_term),
      .lower_ratio_term (lower_ratio_term),
      .state_out        (state_out)
   );

   prk_operator op_u (
      .clk  (clk),
      .keys (keys)
   );

   initial clk = 1'b0;
   always #4 clk = ~clk;

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk16

   task automatic chk_state(input prk_state_t exp, input string msg);
      n_checks++;
      if (state_out !== exp) begin
         fails++;
         $display("wrong value at %0t: %s state %h", $time, msg, state_out);
      end
   endtask : chk_state

   // bounded wait for the selected id to reach a value
   task automatic wait_id(input logic [15:0] exp);
      int i;
      for (i = 0; i < 50 && param_id !== exp; i++) @(negedge clk);
      if (param_id !== exp) begin
         fails++;
         $display("wrong value at %0t: param id wait ran out", $time);
         test_done();
      end
   endtask : wait_id

   // bounded wait for the end of the flash, counting dark phases
   task automatic wait_flash(input string msg);
      int i;
      int darks;
      logic prev;
      darks = 0;
      prev = 1'b0;
      for (i = 0; i < 12 * T_BLINK && state_out !== PRK_SHOW; i++) begin
         if (disp.all_blank === 1'b1 && prev !== 1'b1) begin
            darks++;
         end
         prev = disp.all_blank;
         @(negedge clk);
      end
      if (state_out !== PRK_SHOW) begin
         fails++;
         $display("wrong value at %0t: flash wait ran out", $time);
         test_done();
      end
      chk16(16'(darks), 16'(FLASH_COUNT), msg);
   endtask : wait_flash

   task automatic long_key(input logic [4:0] mask);
      op_u.hold(mask, T_HOLD + 4);
   endtask : long_key

   task automatic goto_div_id();
      repeat (12) op_u.tap(5'h10);
      repeat (2) op_u.tap(5'h04);
      repeat (4) op_u.tap(5'h10);
      chk16(param_id, PULSE_DIV_ID, "ratio parameter id");
   endtask : goto_div_id

   task automatic do_reset();
      @(negedge clk);
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      chk_state(PRK_SELECT, "reset state");
      chk16(param_id, 16'h0000, "reset id");
      chk16(upper_ratio_term, UPPER_RESET, "reset upper");
      chk16(lower_ratio_term, LOWER_RESET, "reset lower");
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask : do_reset

   task automatic test_select_keys();
      repeat (3) op_u.tap(5'h10);
      wait_id(16'h0003);
      chk16(param_id, 16'h0003, "id after three up taps");
      op_u.tap(5'h08);
      wait_id(16'h0002);
      chk16(param_id, 16'h0002, "id after down tap");
      chk_state(PRK_SELECT, "still selecting");
      $display("test_select_keys done");
   endtask : test_select_keys

   task automatic test_short_hold();
      long_key(5'h01);
      chk_state(PRK_SELECT, "long commit on other id");
      do_reset();
      goto_div_id();
      long_key(5'h01);
      chk_state(PRK_PROMPT, "ratio parameter opened");
      chk16({15'h0000, disp.show_prompt}, 16'h0001, "prompt shown");
      op_u.hold(5'h01, T_HOLD - 10);
      chk_state(PRK_PROMPT, "short commit hold");
      op_u.hold(5'h03, 2 * T_HOLD);
      chk_state(PRK_PROMPT, "mode and commit together");
      op_u.hold(5'h02, T_HOLD - 10);
      chk16({15'h0000, disp.lower_sel}, 16'h0000, "short mode hold");
      op_u.tap(5'h06);
      chk_state(PRK_SELECT, "mode with cursor leaves prompt");
      chk16(param_id, PULSE_DIV_ID, "id kept");
      chk16(upper_ratio_term, UPPER_RESET, "upper kept");
      chk16(lower_ratio_term, LOWER_RESET, "lower kept");
      $display("test_short_hold done");
   endtask : test_short_hold

   task automatic test_reset_mid();
      op_u.tap(5'h10);
      do_reset();
      chk16(param_id, 16'h0000, "id cleared by second reset");
      op_u.tap(5'h10);
      wait_id(16'h0001);
      chk16(param_id, 16'h0001, "id after reset and up tap");
      $display("test_reset_mid done");
   endtask : test_reset_mid

   task automatic test_lower_edit();
      do_reset();
      goto_div_id();
      long_key(5'h01);
      op_u.hold(5'h02, 2 * T_HOLD + 4);
      chk16({15'h0000, disp.lower_sel}, 16'h0001, "held mode toggles once");
      long_key(5'h02);
      chk16({15'h0000, disp.lower_sel}, 16'h0000, "mode toggles back");
      long_key(5'h02);
      long_key(5'h01);
      chk_state(PRK_EDIT, "lower term opened");
      chk16(disp.value, LOWER_RESET, "lower value shown");
      chk16({15'h0000, disp.digit_blink}, 16'h0001, "edit digit blinks");
      op_u.tap(5'h04);
      chk16({13'h0000, disp.cursor}, 16'h0001, "cursor on tens");
      repeat (6) op_u.tap(5'h10);
      chk16(disp.value, 16'h003d, "tens stepped up");
      repeat (4) op_u.tap(5'h04);
      chk16({13'h0000, disp.cursor}, 16'h0000, "cursor wrapped");
      repeat (4) op_u.tap(5'h10);
      op_u.tap(5'h08);
      chk16(disp.value, 16'h0040, "units stepped");
      long_key(5'h01);
      chk_state(PRK_FLASH, "valid lower flashes");
      chk16(lower_ratio_term, 16'h0040, "lower stored");
      wait_flash("lower flash count");
      chk16(disp.value, 16'h0040, "lower shown steady");
      chk16({15'h0000, disp.all_blank}, 16'h0000, "display lit");
      op_u.tap(5'h02);
      chk_state(PRK_SELECT, "mode returns to select");
      long_key(5'h01);
      long_key(5'h02);
      long_key(5'h01);
      chk16(disp.value, 16'h0040, "stored lower reopened");
      op_u.tap(5'h10);
      long_key(5'h01);
      chk_state(PRK_REJECT, "lower 65 over upper 1");
      chk16(lower_ratio_term, 16'h0040, "lower kept");
      chk16(disp.value, 16'h0040, "old lower shown");
      chk16({15'h0000, disp.all_blank}, 16'h0000, "reject not flashed");
      op_u.tap(5'h02);
      $display("test_lower_edit done");
   endtask : test_lower_edit

   task automatic test_upper_edit();
      long_key(5'h01);
      long_key(5'h01);
      chk16({15'h0000, disp.lower_sel}, 16'h0000, "upper term opened");
      chk16(disp.value, UPPER_RESET, "upper value shown");
      op_u.tap(5'h10);
      long_key(5'h01);
      chk16(upper_ratio_term, 16'h0002, "upper 2 over lower 64");
      wait_flash("upper flash count");
      op_u.tap(5'h02);
      long_key(5'h01);
      long_key(5'h01);
      op_u.tap(5'h10);
      long_key(5'h01);
      chk_state(PRK_REJECT, "upper 3 over lower 64");
      chk16(upper_ratio_term, 16'h0002, "upper kept");
      chk16(disp.value, 16'h0002, "old upper shown");
      op_u.tap(5'h02);
      chk_state(PRK_SELECT, "back to select");
      $display("test_upper_edit done");
   endtask : test_upper_edit

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   initial begin
      rst_n = 1'b0;
      fails = 0;
      n_checks = 0;
      do_reset();
      $display("test_reset done");
      test_select_keys();
      test_short_hold();
      test_reset_mid();
      test_lower_edit();
      test_upper_edit();
      test_done();
   end

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("wrong value at %0t: run did not end", $time);
      test_done();
   end
endmodule : tb_top
